// *** rtl/sas_pkg.sv ***
`default_nettype none
// shared constants for the successive-approximation sequencer
package sas_pkg;
  // cpu-side byte addresses
  localparam logic [15:0] ADDR_MODE     = 16'hff2a; // converter_mode_control
  localparam logic [15:0] ADDR_RES_LO   = 16'hff18; // result word, low byte
  localparam logic [15:0] ADDR_RES_HI   = 16'hff19; // result word, high byte
  localparam logic [15:0] ADDR_RES_BYTE = 16'hff1a; // conversion_result_high_byte
  localparam logic [15:0] ADDR_CHAN     = 16'hff29; // channel_select
  localparam logic [15:0] ADDR_PINCFG   = 16'hff2b; // pin_function_config
  localparam logic [15:0] ADDR_PDATA    = 16'hff08; // port8 data latch / pin level
  localparam logic [15:0] ADDR_PDIR     = 16'hff28; // port8_direction
  // widths
  localparam int RES_BITS = 10;
  localparam int NUM_PINS = 8;
  // mode register fields
  localparam int MODE_CONV_BIT = 7; // convert_enable_bit
  localparam int MODE_TIME_LSB = 3; // conv_time_sel_2..0 at 5:3
  localparam int MODE_REF_LSB  = 1; // ref_range_sel_1..0 at 2:1
  localparam int MODE_CMP_BIT  = 0; // comparator_enable_bit
  localparam logic [7:0] MODE_WMASK = 8'hbf; // bit 6 always zero
  localparam logic [2:0] CHAN_WMASK = 3'h7;  // channel field width
  // values after reset
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] CHAN_RST   = 8'h00;
  localparam logic [7:0] PINCFG_RST = 8'h00;
  localparam logic [7:0] PDATA_RST  = 8'h00;
  localparam logic [7:0] PDIR_RST   = 8'hff;
  localparam logic [9:0] RES_RST    = 10'h000;
  // conversion clock divider per conv_time_sel value, index 0 rightmost
  localparam logic [7:0][3:0] DIV_TABLE = {4'hc, 4'hc, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hc};
  // sampling length in conversion clocks: 22 or 40 clocks per conversion in all
  localparam logic [4:0] SAMPLE_TICKS_STD = 5'h0c;
  localparam logic [4:0] SAMPLE_TICKS_LOW = 5'h1e;
  localparam logic [9:0] SAR_MSB_CODE     = 10'h200;
  // comparator settling time
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETTLE_NS     = 1000;
  localparam logic [4:0] SETTLE_CYC = 5'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_CONVERT} sas_phase_type;
endpackage
`default_nettype wire

// *** rtl/sas_sar_if.sv ***
`default_nettype none
// link between the sequencer and its approximation register
interface sas_sar_if;
  logic       start;  // load msb trial, begin decisions
  logic       abort;  // drop conversion at once
  logic       tick;   // one conversion clock
  logic       cmp_hi; // comparator: held sample at or above trial
  logic       busy;   // deciding bits
  logic       done;   // one-cycle pulse, result valid
  logic [9:0] trial;  // trial code to resistor string
  logic [9:0] result; // last decided code
  modport ctrl (output start, abort, tick, cmp_hi, input busy, done, trial, result);
  modport core (input start, abort, tick, cmp_hi, output busy, done, trial, result);
endinterface
`default_nettype wire

// *** rtl/sas_tick_gen.sv ***
`default_nettype none
// conversion clock divider; restarts whenever run drops
module sas_tick_gen (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  typedef struct packed {
    logic [3:0] cnt; // cycles since last tick
  } sas_tick_type;

  sas_tick_type st_r;
  sas_tick_type st_nxt;
  logic [3:0]   div_last; // terminal count

  assign div_last = sas_pkg::DIV_TABLE[div_sel] - 4'h1;
  assign tick     = run && (st_r.cnt == div_last);

  // free count while running, held at zero when stopped
  always_comb begin
    st_nxt = st_r;
    if (!run || tick) begin
      st_nxt.cnt = 4'h0;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // sas_tick_gen
`default_nettype wire

// *** rtl/sas_sar_core.sv ***
`default_nettype none
// successive-approximation register, one bit per tick, msb first
module sas_sar_core (
  input  wire logic clk_sys,
  input  wire logic rst,
  sas_sar_if.core   sar
);
  typedef struct packed {
    logic       busy;   // deciding
    logic       done;   // completion pulse
    logic [9:0] code;   // trial code with decided upper bits
    logic [9:0] mask;   // bit now on trial
    logic [9:0] result; // last full result
  } sas_core_type;

  sas_core_type st_r;
  sas_core_type st_nxt;
  logic [9:0]   decided; // code after this tick's comparison

  assign decided    = sar.cmp_hi ? st_r.code : (st_r.code & ~st_r.mask);
  assign sar.busy   = st_r.busy;
  assign sar.done   = st_r.done;
  assign sar.trial  = st_r.code;
  assign sar.result = st_r.result;

  // abort beats start beats tick
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (sar.abort) begin
      st_nxt.busy = 1'b0;
    end else if (sar.start) begin
      st_nxt.busy = 1'b1;
      st_nxt.code = sas_pkg::SAR_MSB_CODE;
      st_nxt.mask = sas_pkg::SAR_MSB_CODE;
    end else if (st_r.busy && sar.tick) begin
      if (st_r.mask[0]) begin // lsb decided
        st_nxt.busy   = 1'b0;
        st_nxt.done   = 1'b1;
        st_nxt.code   = decided;
        st_nxt.result = decided;
      end else begin // keep bit, try next lower one
        st_nxt.code = decided | (st_r.mask >> 1);
        st_nxt.mask = st_r.mask >> 1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // sas_sar_core
`default_nettype wire

// *** rtl/sar_adc_sequencer.sv ***
`default_nettype none
module sar_adc_sequencer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // cpu memory bus, byte wide
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic        bus_bit_wr,
  input  wire logic [2:0]  bus_bit_pos,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  output logic             bus_rvalid,
  output logic             bus_wait,
  // analog front end
  output logic [2:0]       chan_sel,
  output logic             sh_sample,
  output logic             sh_hold,
  output logic [9:0]       dac_code,
  output logic             cmp_enable,
  input  wire logic        cmp_hi,
  // events and status
  output logic             conversion_done_irq,
  output logic             result_suspect,
  // shared port pins
  output logic [7:0]       analog_en,
  input  wire logic [7:0]  pin_din,
  output logic [7:0]       port_dout,
  output logic [7:0]       port_oe
);
  // everything this module remembers
  typedef struct packed {
    sas_pkg::sas_phase_type phase;  // sequencer phase
    logic [7:0]             mode;   // converter_mode_control
    logic [2:0]             chan;   // channel_select
    logic [7:0]             pincfg; // pin_function_config, 1 = analog
    logic [7:0]             pdata;  // port output latch
    logic [7:0]             pdir;   // port8_direction, 1 = input
    logic [9:0]             result; // last completed result
    logic                   irq;    // completion pulse
    logic                   susp;   // last result taken before settling
    logic                   cur_susp; // conversion in flight is suspect
    logic [4:0]             samp;   // sampling ticks elapsed
    logic [4:0]             settle; // cycles since comparator enable
    logic [7:0]             rdata;  // read data latch
    logic                   rvalid; // read answer pulse
    logic                   pend;   // result read in its wait cycle
  } sas_state_type;

  // one flop bank; st_nxt is built by the comb blocks
  // and st_r is the only thing clocked here
  sas_state_type st_r;
  sas_state_type st_nxt;

  // core control travels as one bundle
  // so the two modules cannot drift apart
  sas_sar_if sar (); // link to the approximation register

  logic       conv_on;     // convert_enable_bit
  logic       cmp_on;      // comparator_enable_bit
  logic [2:0] time_sel;    // conv_time_sel_2..0
  logic [1:0] ref_sel;     // ref_range_sel_1..0
  logic       run;         // divider runs outside idle
  logic       tick;        // one conversion clock
  logic [4:0] samp_last;   // last sampling tick
  logic       samp_end;    // sampling finished this cycle
  logic       settled;     // comparator past its settling time
  logic [7:0] rd_mux;      // value for the addressed register
  logic       rd_is_res;   // read targets a result register
  logic [7:0] pin_level;   // port read-back value
  // rd_mux and rd_is_res are plain decode; only
  // the bus branch below registers them

  // field decode of the mode register
  assign conv_on  = st_r.mode[sas_pkg::MODE_CONV_BIT];
  assign cmp_on   = st_r.mode[sas_pkg::MODE_CMP_BIT];
  assign time_sel = st_r.mode[sas_pkg::MODE_TIME_LSB +: 3];
  assign ref_sel  = st_r.mode[sas_pkg::MODE_REF_LSB +: 2];
  // ref_sel only stretches sampling here; the
  // reference itself is analog and outside

  // the wider reference range needs a longer sampling window
  assign samp_last = (ref_sel == 2'h0) ? (sas_pkg::SAMPLE_TICKS_STD - 5'h01)
                                       : (sas_pkg::SAMPLE_TICKS_LOW - 5'h01);
  assign run      = (st_r.phase != sas_pkg::SAS_IDLE);
  assign samp_end = (st_r.phase == sas_pkg::SAS_SAMPLE) && tick && (st_r.samp == samp_last);
  assign settled  = (st_r.settle == sas_pkg::SETTLE_CYC);
  // the counter saturates, so a long idle
  // comparator never wraps back to unsettled

  // conversion clock; timing fields are only safe to change while stopped
  // its own counter keeps the divide out of st_r
  sas_tick_gen u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (run),
    .div_sel (time_sel),
    .tick    (tick)
  );
  // the divider restarts on every run, so the
  // first tick comes a full period in

  // approximation register control
  // start is the last sampling tick, one cycle long
  assign sar.start  = samp_end;
  assign sar.abort  = !conv_on;
  assign sar.tick   = tick;
  assign sar.cmp_hi = cmp_hi;
  // abort is a level: while stopped the core stays
  // idle whatever start says

  sas_sar_core u_core (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sar     (sar)
  );

  // front end: hold from end of sampling until the lsb is decided
  assign sh_sample  = (st_r.phase == sas_pkg::SAS_SAMPLE);
  assign sh_hold    = (st_r.phase == sas_pkg::SAS_CONVERT);
  assign dac_code   = sar.trial;
  assign chan_sel   = st_r.chan;
  assign cmp_enable = cmp_on;
  // both decode one phase register, so sample
  // and hold can never be high together

  // status and bus outputs straight from flip-flops
  assign conversion_done_irq = st_r.irq;
  assign result_suspect      = st_r.susp;
  assign bus_rdata           = st_r.rdata;
  assign bus_rvalid          = st_r.rvalid;
  assign bus_wait            = st_r.pend;
  assign analog_en           = st_r.pincfg;
  // bus_wait is a flop: the stretch shows in the
  // cycle after the request, as the cpu expects

  // per-pin port logic: a pin given to the converter never drives
  // and reads back zero, the others behave as plain port bits
  // an analog pin keeps its buffer off even when
  // its direction bit asks for output
  genvar gi;
  generate
    for (gi = 0; gi < sas_pkg::NUM_PINS; gi++) begin : g_pin
      assign port_dout[gi] = st_r.pdata[gi];
      assign port_oe[gi]   = !st_r.pdir[gi] && !st_r.pincfg[gi];
      assign pin_level[gi] = st_r.pincfg[gi] ? 1'b0 :
                             (st_r.pdir[gi] ? pin_din[gi] : st_r.pdata[gi]);
    end
  endgenerate

  // read decode; unmapped addresses answer zero
  // data are latched at the request, so a result
  // landing in the wait cycle cannot tear a read
  always_comb begin
    rd_mux    = 8'h00;
    rd_is_res = 1'b0;
    unique case (bus_addr)
      sas_pkg::ADDR_MODE: begin
        rd_mux = st_r.mode & sas_pkg::MODE_WMASK;
      end
      sas_pkg::ADDR_RES_LO: begin
        // two lsbs on top, six zeros below
        rd_mux    = {st_r.result[1:0], 6'h00};
        rd_is_res = 1'b1;
      end
      sas_pkg::ADDR_RES_HI: begin
        // high byte of the left-justified word
        rd_mux    = st_r.result[9:2];
        rd_is_res = 1'b1;
      end
      sas_pkg::ADDR_RES_BYTE: begin
        // same eight bits for byte readers
        rd_mux    = st_r.result[9:2];
        rd_is_res = 1'b1;
      end
      sas_pkg::ADDR_CHAN: begin
        rd_mux = {5'h00, st_r.chan};
      end
      sas_pkg::ADDR_PINCFG: begin
        rd_mux = st_r.pincfg;
      end
      sas_pkg::ADDR_PDATA: begin
        // pin level, latch or zero per pin
        rd_mux = pin_level;
      end
      sas_pkg::ADDR_PDIR: begin
        rd_mux = st_r.pdir;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // byte write takes the data, bit write replaces one bit with data bit 0
  // a byte write wins when both strobes come
  function automatic logic [7:0] sas_merge(input logic [7:0] old, input logic [7:0] mask);
    logic [7:0] val;
    val = old;
    if (bus_wr) begin
      val = bus_wdata;
    end else if (bus_bit_wr) begin
      val[bus_bit_pos] = bus_wdata[0];
    end
    return val & mask;
  endfunction

  // next-state logic for registers, bus answers and the sequencer
  always_comb begin
    st_nxt        = st_r;
    st_nxt.irq    = 1'b0; // pulse by default
    st_nxt.rvalid = 1'b0;

    // writes and reads have separate paths
    // cpu writes, byte or single bit
    if (bus_wr || bus_bit_wr) begin
      unique case (bus_addr)
        sas_pkg::ADDR_MODE: begin
          st_nxt.mode = sas_merge(st_r.mode, sas_pkg::MODE_WMASK);
        end
        sas_pkg::ADDR_CHAN: begin
          // only the low three bits exist
          st_nxt.chan = 3'(sas_merge({5'h00, st_r.chan},
                                     {5'h00, sas_pkg::CHAN_WMASK}));
        end
        sas_pkg::ADDR_PINCFG: begin
          st_nxt.pincfg = sas_merge(st_r.pincfg, 8'hff);
        end
        sas_pkg::ADDR_PDATA: begin
          // latch only; pins follow via port_dout
          st_nxt.pdata = sas_merge(st_r.pdata, 8'hff);
        end
        sas_pkg::ADDR_PDIR: begin
          // 1 makes the pin an input
          st_nxt.pdir = sas_merge(st_r.pdir, 8'hff);
        end
        default: begin
          // results and unmapped addresses ignore writes
        end
      endcase
    end

    // reads: results answer one cycle later than the rest;
    // a read arriving during the wait cycle is ignored
    if (st_r.pend) begin
      st_nxt.pend   = 1'b0;
      // second cycle of a result read: answer
      st_nxt.rvalid = 1'b1;
    end else if (bus_rd) begin
      // results stretch by one cycle, the rest answer now
      st_nxt.rdata  = rd_mux;
      st_nxt.pend   = rd_is_res;
      st_nxt.rvalid = !rd_is_res;
    end

    // settling counter restarts whenever the comparator is switched off
    if (!cmp_on) begin
      // comparator off: settling starts over
      st_nxt.settle = 5'h00;
    end else if (!settled) begin
      // count to the settling time, then stop
      st_nxt.settle = st_r.settle + 5'h01;
    end

    // phase changes only here; outputs decode it
    // sequencer; dropping the enable ends any phase at the next edge
    unique case (st_r.phase)
      sas_pkg::SAS_IDLE: begin
        // wait for the enable bit
        if (conv_on) begin
          st_nxt.phase    = sas_pkg::SAS_SAMPLE;
          st_nxt.samp     = 5'h00;
          // only the first conversion of a run is checked for settling
          st_nxt.cur_susp = !settled;
        end
      end
      sas_pkg::SAS_SAMPLE: begin
        if (!conv_on) begin
          // stopped while sampling: nothing to keep
          st_nxt.phase = sas_pkg::SAS_IDLE;
        end else if (samp_end) begin
          // window over: the core takes the sample
          st_nxt.phase = sas_pkg::SAS_CONVERT;
          st_nxt.samp  = 5'h00;
        end else if (tick) begin
          // count sampling ticks
          st_nxt.samp = st_r.samp + 5'h01;
        end
      end
      sas_pkg::SAS_CONVERT: begin
        if (!conv_on) begin
          // aborted: result registers keep the last finished code
          st_nxt.phase = sas_pkg::SAS_IDLE;
        end else if (sar.done) begin
          // lsb decided: publish and go again
          st_nxt.result   = sar.result;
          st_nxt.irq      = 1'b1;
          st_nxt.susp     = st_r.cur_susp;
          st_nxt.cur_susp = 1'b0;
          st_nxt.phase    = sas_pkg::SAS_SAMPLE;
          st_nxt.samp     = 5'h00;
        end
      end
    endcase
  end

  // one register for this module's state; named fields reset to package values, the rest to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r          <= '0;
      // then every field with a named reset value
      st_r.phase    <= sas_pkg::SAS_IDLE;
      st_r.mode     <= sas_pkg::MODE_RST;
      st_r.chan     <= sas_pkg::CHAN_RST[2:0];
      st_r.pincfg   <= sas_pkg::PINCFG_RST;
      st_r.pdata    <= sas_pkg::PDATA_RST;
      st_r.pdir     <= sas_pkg::PDIR_RST;
      st_r.result   <= sas_pkg::RES_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // sar_adc_sequencer
`default_nettype wire

// *** verif/sas_analog_src.sv ***
`default_nettype none
// analog sources on the shared pins plus the comparator they feed
module sas_analog_src (
  input  wire logic             clk_sys,
  input  wire logic [2:0]       chan_sel,
  input  wire logic             sh_sample,
  input  wire logic [9:0]       dac_code,
  input  wire logic [7:0][9:0]  level,
  output logic                  cmp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held_r = 10'h000; // captured input, zero until the first sample
  // track the selected pin while sampling, freeze it otherwise
  always @(posedge clk_sys) begin
    if (sh_sample) begin
      held_r <= level[chan_sel];
    end
  end
  // comparator: held sample at or above the trial code
  assign cmp_hi = (held_r >= dac_code);
endmodule // sas_analog_src
`default_nettype wire

// *** verif/sas_monitor.sv ***
`default_nettype none
// watches the sequencer pins for bus timing, phase order and event pulses
module sas_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_bit_wr,
  input wire logic [2:0]  bus_bit_pos,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_rvalid,
  input wire logic        bus_wait,
  input wire logic        sh_sample,
  input wire logic        sh_hold,
  input wire logic [9:0]  dac_code,
  input wire logic        cmp_enable,
  input wire logic        conversion_done_irq,
  input wire logic [7:0]  analog_en,
  input wire logic [7:0]  port_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic res_rd;   // accepted read of a result byte
  logic mode_wr;  // byte write, or bit write to bit 7, of the mode register
  logic run_bit;  // value written to the conversion enable bit
  assign res_rd = bus_rd && !bus_wait && (bus_addr == sas_pkg::ADDR_RES_LO ||
                  bus_addr == sas_pkg::ADDR_RES_HI || bus_addr == sas_pkg::ADDR_RES_BYTE);
  assign mode_wr = (bus_addr == sas_pkg::ADDR_MODE) &&
                   (bus_wr || (bus_bit_wr && bus_bit_pos == 3'h7));
  // byte write wins over a bit write in the same cycle
  assign run_bit = bus_wr ? bus_wdata[7] : bus_wdata[0];
  sequence s_res_answer;
    (bus_wait && !bus_rvalid) ##1 (bus_rvalid && !bus_wait);
  endsequence
  sequence s_stopped;
    (!sh_sample && !sh_hold && !conversion_done_irq) [*3];
  endsequence
  property p_res_wait;
    res_rd |=> s_res_answer;
  endproperty
  a_res_wait: assert property (p_res_wait) else $error("result read lacks wait cycle");
  property p_plain_rd;
    bus_rd && !bus_wait && bus_addr == sas_pkg::ADDR_MODE |=> bus_rvalid && !bus_wait;
  endproperty
  a_plain_rd: assert property (p_plain_rd) else $error("mode read answer late");
  property p_irq_pulse;
    conversion_done_irq |=> !conversion_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_stop;
    // a new mode write may restart at once, so only check while none follows
    mode_wr && !run_bit ##1 (!mode_wr) [*2] |-> s_stopped;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion kept running after stop");
  property p_start;
    mode_wr && run_bit && !sh_sample && !sh_hold |=> ##1 sh_sample;
  endproperty
  a_start: assert property (p_start) else $error("enable did not start sampling");
  property p_resume;
    conversion_done_irq |-> ##[0:1] sh_sample;
  endproperty
  a_resume: assert property (p_resume) else $error("no new sample after completion");
  property p_msb;
    $rose(sh_hold) |-> dac_code == sas_pkg::SAR_MSB_CODE && !sh_sample;
  endproperty
  a_msb: assert property (p_msb) else $error("first trial is not the msb");
  property p_cmp;
    logic v;
    (bus_wr && bus_addr == sas_pkg::ADDR_MODE, v = bus_wdata[0]) |=> cmp_enable == v;
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enable mismatch");
  property p_pins;
    (port_oe & analog_en) == 8'h00;
  endproperty
  a_pins: assert property (p_pins) else $error("analog pin driven as output");
  property p_reset;
    disable iff (1'b0) rst |=> !conversion_done_irq && !sh_sample && !sh_hold && !cmp_enable;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule // sas_monitor
`default_nettype wire

// *** verif/tb_sar_adc_sequencer.sv ***
`default_nettype none
module tb_sar_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, bus_rd = 1'b0, bus_wr = 1'b0, bus_bit_wr = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [2:0]  bus_bit_pos = 3'h0;
  logic [7:0]  bus_wdata = 8'h00, pin_din = 8'h00, bus_rdata, analog_en, port_dout, port_oe;
  logic        bus_rvalid, bus_wait, sh_sample, sh_hold, cmp_enable, cmp_hi;
  logic        conversion_done_irq, result_suspect;
  logic [2:0]  chan_sel;
  logic [9:0]  dac_code, val;
  logic [7:0][9:0] levels = '0;
  logic [7:0]  exp_q[$]; // expected read data, oldest first
  int error_cnt = 0, samples_checked = 0, k, ch;
  always #20 clk_sys = ~clk_sys;
  sar_adc_sequencer sar_adc_sequencer_i (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_bit_pos(bus_bit_pos),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .bus_wait(bus_wait),
    .chan_sel(chan_sel), .sh_sample(sh_sample), .sh_hold(sh_hold), .dac_code(dac_code),
    .cmp_enable(cmp_enable), .cmp_hi(cmp_hi), .conversion_done_irq(conversion_done_irq),
    .result_suspect(result_suspect), .analog_en(analog_en), .pin_din(pin_din),
    .port_dout(port_dout), .port_oe(port_oe));
  sas_analog_src sas_analog_src_i (.clk_sys(clk_sys), .chan_sel(chan_sel),
    .sh_sample(sh_sample), .dac_code(dac_code), .level(levels), .cmp_hi(cmp_hi));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // byte write, strobe held for exactly one sampling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // single-bit write to the mode register
  task automatic bwr(input logic [2:0] p, input logic v);
    @(posedge clk_sys);
    bus_addr <= sas_pkg::ADDR_MODE; bus_bit_pos <= p; bus_wdata <= {7'h00, v};
    bus_bit_wr <= 1'b1;
    @(posedge clk_sys);
    bus_bit_wr <= 1'b0;
  endtask
  // read request; spacing of two idle edges suits result reads too
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_addr <= a; bus_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      if (conversion_done_irq === 1'b1) break;
    end
    if (i == 300) begin
      chk("irq timeout", 16'h0001, 16'h0000);
      report_and_stop();
    end
  endtask
  // answer watcher: every read answer consumes the oldest expectation
  always @(negedge clk_sys) begin
    if (bus_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected rvalid", 16'h0000, 16'h0001);
      else chk("bus_rdata", {8'h00, exp_q.pop_front()}, {8'h00, bus_rdata});
    end
  end
  initial begin
    k = $urandom(47);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(sas_pkg::ADDR_MODE, 8'h00);
    rd(sas_pkg::ADDR_RES_HI, 8'h00);
    rd(sas_pkg::ADDR_RES_LO, 8'h00);
    rd(16'hff00, 8'h00);
    wr(sas_pkg::ADDR_MODE, 8'h7e);
    rd(sas_pkg::ADDR_MODE, 8'h3e);
    bwr(3'h0, 1'b1);
    rd(sas_pkg::ADDR_MODE, 8'h3f);
    // fast timing, comparator off: first result must be flagged
    wr(sas_pkg::ADDR_MODE, 8'h28);
    bwr(3'h7, 1'b1);
    wait_irq();
    chk("result_suspect", 16'h0001, {15'h0, result_suspect});
    bwr(3'h7, 1'b0);
    // shared pins: pin 0 analog, low nibble input, high nibble output
    pin_din <= 8'($urandom);
    wr(sas_pkg::ADDR_PINCFG, 8'h01);
    wr(sas_pkg::ADDR_PDIR, 8'h0f);
    wr(sas_pkg::ADDR_PDATA, 8'ha5);
    @(negedge clk_sys);
    chk("analog_en", 16'h0001, {8'h00, analog_en});
    chk("port_oe", 16'h00f0, {8'h00, port_oe});
    chk("port_dout", 16'h00a5, {8'h00, port_dout});
    rd(sas_pkg::ADDR_PDATA, ((8'ha5 & 8'hf0) | (pin_din & 8'h0f)) & 8'hfe);
    wr(sas_pkg::ADDR_PINCFG, 8'hff);
    for (k = 0; k < 4; k++) begin
      ch = $urandom % 8;
      val = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($urandom);
      levels[ch] = val;
      wr(sas_pkg::ADDR_CHAN, 8'(ch));
      @(negedge clk_sys);
      chk("chan_sel", 16'(ch), {13'h0, chan_sel});
      wr(sas_pkg::ADDR_MODE, 8'h29);
      repeat (30) @(posedge clk_sys); // comparator settles before the run
      bwr(3'h7, 1'b1);
      wait_irq();
      chk("result_suspect", 16'h0000, {15'h0, result_suspect});
      wait_irq();
      bwr(3'h7, 1'b0);
      rd(sas_pkg::ADDR_RES_HI, val[9:2]);
      rd(sas_pkg::ADDR_RES_LO, {val[1:0], 6'h00});
      rd(sas_pkg::ADDR_RES_BYTE, val[9:2]);
    end
    // abort mid-conversion: no event, old result stays, result is read-only
    levels[ch] = ~val;
    bwr(3'h7, 1'b1);
    repeat (34) @(posedge clk_sys);
    bwr(3'h7, 1'b0);
    repeat (80) begin
      @(negedge clk_sys);
      if (conversion_done_irq === 1'b1) chk("irq after stop", 16'h0000, 16'h0001);
    end
    wr(sas_pkg::ADDR_RES_HI, 8'h55);
    rd(sas_pkg::ADDR_RES_HI, val[9:2]);
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0) chk("missing answers", 16'h0000, 16'(exp_q.size()));
    report_and_stop();
  end
endmodule // tb_sar_adc_sequencer
bind sar_adc_sequencer sas_monitor sas_monitor_i (.clk_sys(clk_sys), .rst(rst),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr),
  .bus_bit_pos(bus_bit_pos), .bus_wdata(bus_wdata), .bus_rvalid(bus_rvalid),
  .bus_wait(bus_wait), .sh_sample(sh_sample), .sh_hold(sh_hold), .dac_code(dac_code),
  .cmp_enable(cmp_enable), .conversion_done_irq(conversion_done_irq),
  .analog_en(analog_en), .port_oe(port_oe));
`default_nettype wire
